// >>> hdl/psa_top.sv
// port status, interrupt, automatic port choice and local serial target
`timescale 1ns/1ps
`include "psa_defines.svh"

// Summary of operation
// - in register mode an interrupt is a low-to-high step of irq_o
// - power sense, selected port or its clock detect changing raises it
// - offset 0x01 reads power sense, selected port and clock detect
// - reading offset 0x01 drops the interrupt output low
// - in pin mode irq_o mirrors the selected port's clock detect
// - automatic choice only in register mode, control bits 3 to 5
// - automatic choice uses priority field and four power sense bits
// - any of the four ports may be the priority port
// - select pin picks register interface or control pins
// - serial interface is target only: port, edge, power, ddc level
// - any-power flag is high while any power sense input is high
// - selected hotplug follows sink, others follow their power sense
module psa_top #(
    parameter logic [6:0] DEV_ADDR = `PSA_DEV_ADDR_DEF  // arbitrary value
) (
    input  wire logic                      clk_i,          // 100 MHz clock
    input  wire logic                      rst_n_i,        // sync reset, low
    input  wire psa_pkg::psa_port_sense_t  port_sense_i,   // per-port pins
    input  wire logic                      sink_hotplug_in_i, // sink hotplug
    input  wire logic                      reg_mode_sel_i, // high: registers
    input  wire logic [1:0]                port_sel_pins_i, // pin port select
    input  wire logic                      scl_i,          // serial clock
    input  wire logic                      sda_i,          // serial data in
    output logic                           sda_o,          // data out, low
    output logic                           sda_oe_o,       // pulls sda low
    output logic                           irq_o,          // interrupt/detect
    output logic                           any_source_power_flag_o, // power
    output logic [3:0]                     port_hotplug_out_o, // per port
    output logic [1:0]                     selected_port_o, // active port
    output logic [1:0]                     power_mode_o,   // power setting
    output logic [1:0]                     edge_rate_o,    // output edge rate
    output logic [1:0]                     ddc_low_level_select_o // ddc level
);
    import psa_pkg::*;

    // =====================================================================
    // input synchronisation
    // =====================================================================
    logic [3:0]  pwr;
    logic [3:0]  clk_det;
    logic        sink_hp;
    logic        reg_mode;
    logic [1:0]  pin_sel;
    logic        scl;
    logic        sda;

    psa_sync #(.W(14)) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .async_i ({port_sense_i.source_power_sense,
                   port_sense_i.clock_detect,
                   sink_hotplug_in_i, reg_mode_sel_i,
                   port_sel_pins_i, scl_i, sda_i}),
        .sync_o  ({pwr, clk_det, sink_hp, reg_mode, pin_sel, scl, sda})
    );

    // =====================================================================
    // serial target state
    // =====================================================================
    psa_i2c_state_t state_q;
    logic           scl_prev_q;
    logic           sda_prev_q;
    logic [7:0]     shreg_q;
    logic [3:0]     bit_cnt_q;
    logic [7:0]     ptr_q;
    logic           ptr_phase_q;
    logic           rw_q;
    logic           more_q;
    logic           drv_low_q;
    logic [7:0]     control_q;
    logic [7:0]     aux_q;
    logic           status_read;
    logic           wr_stb;
    logic [7:0]     rd_byte;

    logic [1:0]     sel_q;
    psa_status_t    status;

    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    assign scl_rise   = scl && !scl_prev_q;
    assign scl_fall   = !scl && scl_prev_q;
    assign start_cond = scl && scl_prev_q && sda_prev_q && !sda;
    assign stop_cond  = scl && scl_prev_q && !sda_prev_q && sda;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl;
            sda_prev_q <= sda;
        end
    end

    // readable byte at the current pointer
    always_comb begin
        unique case (ptr_q)
            `PSA_REG_STATUS:  rd_byte = status;
            `PSA_REG_CONTROL: rd_byte = control_q;
            `PSA_REG_AUX:     rd_byte = aux_q;
            default:          rd_byte = `PSA_BYTE_ZERO;
        endcase
    end

    // target-only protocol engine: never drives scl
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q     <= PSA_IDLE;
            shreg_q     <= `PSA_BYTE_ZERO;
            bit_cnt_q   <= '0;
            ptr_q       <= `PSA_BYTE_ZERO;
            ptr_phase_q <= 1'b0;
            rw_q        <= 1'b0;
            more_q      <= 1'b0;
            drv_low_q   <= 1'b0;
        end else if (!reg_mode || stop_cond) begin
            state_q   <= PSA_IDLE;
            drv_low_q <= 1'b0;
        end else if (start_cond) begin
            state_q   <= PSA_ADDR;
            bit_cnt_q <= '0;
            drv_low_q <= 1'b0;
        end else if (scl_rise) begin
            unique case (state_q)
                PSA_ADDR, PSA_WRITE: begin
                    shreg_q   <= {shreg_q[6:0], sda};
                    bit_cnt_q <= bit_cnt_q + 4'h1;
                end
                PSA_READ_ACK: more_q <= !sda;
                default: ;
            endcase
        end else if (scl_fall) begin
            unique case (state_q)
                PSA_ADDR: begin
                    if (bit_cnt_q == `PSA_BITS_PER_BYTE) begin
                        if (shreg_q[7:1] == DEV_ADDR) begin
                            rw_q      <= shreg_q[0];
                            drv_low_q <= 1'b1;
                            state_q   <= PSA_ACK_ADDR;
                        end else begin
                            state_q <= PSA_IDLE;
                        end
                    end
                end
                PSA_ACK_ADDR: begin
                    if (rw_q) begin
                        shreg_q   <= rd_byte;
                        drv_low_q <= !rd_byte[7];
                        bit_cnt_q <= 4'h1;
                        ptr_q     <= ptr_q + 8'h01;
                        state_q   <= PSA_READ;
                    end else begin
                        drv_low_q   <= 1'b0;
                        bit_cnt_q   <= '0;
                        ptr_phase_q <= 1'b1;
                        state_q     <= PSA_WRITE;
                    end
                end
                PSA_WRITE: begin
                    if (bit_cnt_q == `PSA_BITS_PER_BYTE) begin
                        if (ptr_phase_q) begin
                            ptr_q       <= shreg_q;
                            ptr_phase_q <= 1'b0;
                        end else begin
                            ptr_q <= ptr_q + 8'h01;
                        end
                        drv_low_q <= 1'b1;
                        state_q   <= PSA_ACK_WRITE;
                    end
                end
                PSA_ACK_WRITE: begin
                    drv_low_q <= 1'b0;
                    bit_cnt_q <= '0;
                    state_q   <= PSA_WRITE;
                end
                PSA_READ: begin
                    if (bit_cnt_q == `PSA_BITS_PER_BYTE) begin
                        drv_low_q <= 1'b0;
                        state_q   <= PSA_READ_ACK;
                    end else begin
                        shreg_q   <= {shreg_q[6:0], 1'b0};
                        drv_low_q <= !shreg_q[6];
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                end
                PSA_READ_ACK: begin
                    if (more_q) begin
                        shreg_q   <= rd_byte;
                        drv_low_q <= !rd_byte[7];
                        bit_cnt_q <= 4'h1;
                        ptr_q     <= ptr_q + 8'h01;
                        state_q   <= PSA_READ;
                    end else begin
                        state_q <= PSA_IDLE;
                    end
                end
                PSA_IDLE: ;
            endcase
        end
    end

    // a byte leaves for the host when loaded at these two points
    assign status_read = reg_mode && !stop_cond && !start_cond && scl_fall
                         && ptr_q == `PSA_REG_STATUS
                         && ((state_q == PSA_ACK_ADDR && rw_q)
                             || (state_q == PSA_READ_ACK && more_q));

    assign wr_stb = reg_mode && !stop_cond && !start_cond && scl_fall
                    && state_q == PSA_WRITE && !ptr_phase_q
                    && bit_cnt_q == `PSA_BITS_PER_BYTE;

    assign sda_o    = 1'b0;
    assign sda_oe_o = drv_low_q;

    // =====================================================================
    // writable registers
    // =====================================================================
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            control_q <= `PSA_CONTROL_RST;
            aux_q     <= `PSA_AUX_RST;
        end else if (wr_stb) begin
            if (ptr_q == `PSA_REG_CONTROL)
                control_q <= shreg_q;
            if (ptr_q == `PSA_REG_AUX)
                aux_q <= shreg_q;
        end
    end

    // =====================================================================
    // port selection
    // =====================================================================
    logic [1:0] prio;
    logic [1:0] auto_sel;
    logic [1:0] cand;
    logic       found;
    logic [1:0] sel_d;

    assign prio =
        control_q[`PSA_CTRL_PRIO_MSB:`PSA_CTRL_PRIO_LSB];

    // walk from the priority port onward; hold if nothing is powered
    always_comb begin
        cand     = 2'h0;
        found    = 1'b0;
        auto_sel = sel_q;
        for (int k = 0; k < 4; k++) begin
            cand = prio + 2'(k);
            if (!found && pwr[cand]) begin
                auto_sel = cand;
                found    = 1'b1;
            end
        end
    end

    always_comb begin
        if (!reg_mode)
            sel_d = pin_sel;
        else if (control_q[`PSA_CTRL_AUTO_BIT])
            sel_d = auto_sel;
        else
            sel_d = control_q[`PSA_CTRL_SEL_MSB:`PSA_CTRL_SEL_LSB];
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i)
            sel_q <= 2'h0;
        else
            sel_q <= sel_d;
    end

    // =====================================================================
    // status and interrupt
    // =====================================================================
    logic [3:0] pwr_prev_q;
    logic [1:0] sel_prev_q;
    logic       det_prev_q;
    logic       sel_det;
    logic       irq_q;
    logic       irq_event;
    logic       irq_out_q;

    assign sel_det = clk_det[sel_q];

    always_comb begin
        status                    = '0;
        status.clock_detect       = sel_det;
        status.selected_port      = sel_q;
        status.source_power_sense = pwr;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pwr_prev_q <= 4'h0;
            sel_prev_q <= 2'h0;
            det_prev_q <= 1'b0;
        end else begin
            pwr_prev_q <= pwr;
            sel_prev_q <= sel_q;
            det_prev_q <= sel_det;
        end
    end

    assign irq_event = reg_mode && (pwr != pwr_prev_q
                       || sel_q != sel_prev_q || sel_det != det_prev_q);

    // a new event in the clearing cycle keeps the request pending
    always_ff @(posedge clk_i) begin
        if (!rst_n_i)
            irq_q <= 1'b0;
        else if (irq_event)
            irq_q <= 1'b1;
        else if (status_read || !reg_mode)
            irq_q <= 1'b0;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i)
            irq_out_q <= 1'b0;
        else if (reg_mode)
            irq_out_q <= irq_q;
        else
            irq_out_q <= sel_det;
    end

    // =====================================================================
    // pin outputs
    // =====================================================================
    logic [3:0] hp_q;
    logic       any_pwr_q;
    logic [1:0] pmode_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            hp_q      <= 4'h0;
            any_pwr_q <= 1'b0;
            pmode_q   <= 2'h0;
        end else begin
            for (int i = 0; i < 4; i++)
                hp_q[i] <= (sel_q == 2'(i)) ? sink_hp : pwr[i];
            any_pwr_q <= |pwr;
            pmode_q   <= reg_mode
                         ? control_q[`PSA_CTRL_PWR_MSB:`PSA_CTRL_PWR_LSB]
                         : 2'h0;
        end
    end

    assign irq_o                   = irq_out_q;
    assign any_source_power_flag_o = any_pwr_q;
    assign port_hotplug_out_o      = hp_q;
    assign selected_port_o         = sel_q;
    assign power_mode_o            = pmode_q;
    assign edge_rate_o = aux_q[`PSA_AUX_EDGE_MSB:`PSA_AUX_EDGE_LSB];
    assign ddc_low_level_select_o = aux_q[`PSA_AUX_DDC_MSB:`PSA_AUX_DDC_LSB];

endmodule

// >>> hdl/psa_defines.svh
// constants of the port status, interrupt and automatic choice block
`ifndef PSA_DEFINES_SVH
`define PSA_DEFINES_SVH

// register offsets of the local serial interface
`define PSA_REG_STATUS    8'h01
`define PSA_REG_CONTROL   8'h02
`define PSA_REG_AUX       8'h03

// control register fields
`define PSA_CTRL_SEL_LSB  0
`define PSA_CTRL_SEL_MSB  1
`define PSA_CTRL_PRIO_LSB 3
`define PSA_CTRL_PRIO_MSB 4
`define PSA_CTRL_AUTO_BIT 5
`define PSA_CTRL_PWR_LSB  6
`define PSA_CTRL_PWR_MSB  7

// auxiliary register fields
`define PSA_AUX_EDGE_LSB  0
`define PSA_AUX_EDGE_MSB  1
`define PSA_AUX_DDC_LSB   2
`define PSA_AUX_DDC_MSB   3

// reset values
`define PSA_CONTROL_RST   8'h00
`define PSA_AUX_RST       8'h00
`define PSA_BYTE_ZERO     8'h00

// serial interface framing
`define PSA_BITS_PER_BYTE 4'h8
`define PSA_DEV_ADDR_DEF  7'h2C

`endif

// >>> hdl/psa_pkg.sv
// types shared by the port status, interrupt and automatic choice block
package psa_pkg;

    typedef enum logic [2:0] {
        PSA_IDLE,
        PSA_ADDR,
        PSA_ACK_ADDR,
        PSA_WRITE,
        PSA_ACK_WRITE,
        PSA_READ,
        PSA_READ_ACK
    } psa_i2c_state_t;

    // per-port sense inputs from the pins and the clock detectors
    typedef struct packed {
        logic [3:0] source_power_sense;
        logic [3:0] clock_detect;
    } psa_port_sense_t;

    // byte returned at the status offset
    typedef struct packed {
        logic       reserved;
        logic       clock_detect;
        logic [1:0] selected_port;
        logic [3:0] source_power_sense;
    } psa_status_t;

endpackage

// >>> hdl/psa_sync.sv
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module psa_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,    // system clock
    input  wire logic         rst_n_i,  // synchronous reset, active low
    input  wire logic [W-1:0] async_i,  // level from outside the domain
    output logic      [W-1:0] sync_o    // level safe to use
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule

// >>> verification/psa_top_props.sv
// concurrent checks on the ports of the port status block
`timescale 1ns/1ps
module psa_top_props (
    input wire logic                     clk_i,             // clock
    input wire logic                     rst_n_i,           // reset, low
    input wire psa_pkg::psa_port_sense_t port_sense_i,      // sense pins
    input wire logic                     sink_hotplug_in_i, // sink hotplug
    input wire logic                     reg_mode_sel_i,    // mode select
    input wire logic [1:0]               port_sel_pins_i,   // pin select
    input wire logic                     scl_i,             // serial clock
    input wire logic                     sda_oe_o,          // data pull
    input wire logic                     irq_o,             // interrupt
    input wire logic                     any_source_power_flag_o, // power
    input wire logic [3:0]               port_hotplug_out_o, // hotplug
    input wire logic [1:0]               selected_port_o    // active port
);
    import psa_pkg::*;
    // ========================================
    // helpers
    logic [3:0] pwr;
    logic [3:0] cd;
    logic [3:0] hp_exp;
    logic [7:0] sig_d;
    logic [7:0] sig_q;
    logic [3:0] quiet_q;
    logic [3:0] sclq_q;
    assign pwr   = port_sense_i.source_power_sense;
    assign cd    = port_sense_i.clock_detect;
    assign sig_d = {pwr, cd[selected_port_o], selected_port_o, reg_mode_sel_i};
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            hp_exp[i] = (selected_port_o == 2'(i)) ? sink_hotplug_in_i : pwr[i];
        end
    end
    always_ff @(posedge clk_i) begin
        sig_q <= sig_d;
    end
    // cycles since a cause of an interrupt last changed
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || sig_d != sig_q) begin
            quiet_q <= 4'h0;
        end else if (quiet_q != 4'hF) begin
            quiet_q <= quiet_q + 4'h1;
        end
    end
    // cycles since the serial clock last fell
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || $fell(scl_i)) begin
            sclq_q <= 4'h0;
        end else if (sclq_q != 4'hF) begin
            sclq_q <= sclq_q + 4'h1;
        end
    end
    // ========================================
    // assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    a_any_power: assert property (
        $stable(pwr)[*6] |-> any_source_power_flag_o == |pwr
    ) else $error("any power flag wrong");
    a_hotplug_follow: assert property (
        $stable({pwr, sink_hotplug_in_i, selected_port_o})[*6]
        |-> port_hotplug_out_o == hp_exp
    ) else $error("hotplug output wrong");
    a_pin_select: assert property (
        (!reg_mode_sel_i && $stable({reg_mode_sel_i, port_sel_pins_i}))[*6]
        |-> selected_port_o == port_sel_pins_i
    ) else $error("pin select not followed");
    a_pin_irq_mirror: assert property (
        (!reg_mode_sel_i && $stable({reg_mode_sel_i, cd, selected_port_o}))[*6]
        |-> irq_o == cd[selected_port_o]
    ) else $error("irq does not mirror clock detect");
    a_irq_on_power: assert property (
        (reg_mode_sel_i && scl_i && $stable(reg_mode_sel_i))[*6]
        ##1 $changed(pwr) |-> ##[1:6] irq_o
    ) else $error("no interrupt after power change");
    a_irq_has_cause: assert property (
        $rose(irq_o) && reg_mode_sel_i |-> quiet_q < 4'h8
    ) else $error("interrupt without cause");
    a_irq_read_clear: assert property (
        reg_mode_sel_i[*8] ##0 $fell(irq_o) |-> sclq_q < 4'h8
    ) else $error("interrupt dropped without bus read");
    a_sda_hold: assert property (
        scl_i[*5] |-> $stable(sda_oe_o)
    ) else $error("data changed while serial clock high");
endmodule

bind psa_top psa_top_props props_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .port_sense_i(port_sense_i),
    .sink_hotplug_in_i(sink_hotplug_in_i), .reg_mode_sel_i(reg_mode_sel_i),
    .port_sel_pins_i(port_sel_pins_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o),
    .irq_o(irq_o), .any_source_power_flag_o(any_source_power_flag_o),
    .port_hotplug_out_o(port_hotplug_out_o),
    .selected_port_o(selected_port_o)
);

// >>> verification/psa_host_model.sv
// local serial host that reaches the registers of the block
`timescale 1ns/1ps
module psa_host_model #(
    parameter logic [6:0] ADDR = 7'h2C, // target address, arbitrary
    parameter int         QTR  = 250    // quarter bit, 100 kHz
) (
    input  wire logic clk_i,     // system clock
    input  wire logic sda_i,     // resolved data line
    output logic      scl_o,     // serial clock
    output logic      sda_pull_o // high pulls the data line low
);
    initial begin
        scl_o      = 1'b1;
        sda_pull_o = 1'b0;
    end
    task automatic step(input logic scl, input logic pull);
        scl_o      <= scl;
        sda_pull_o <= pull;
        repeat (QTR) @(posedge clk_i);
    endtask
    // data changes only while the clock is low
    task automatic bit_io(input logic b, output logic s);
        step(1'b0, !b);
        step(1'b1, !b);
        s = sda_i;
        step(1'b1, !b);
        step(1'b0, !b);
    endtask
    task automatic start();
        if (!scl_o) begin
            step(1'b0, 1'b0);
            step(1'b1, 1'b0);
        end
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask
    task automatic stop();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask
    task automatic xbyte(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
    endtask
    task automatic write_regs(input logic [7:0] ptr, input logic [15:0] d,
                              output logic ok);
        logic [8:0] r0;
        logic [8:0] r1;
        logic [8:0] r2;
        logic [8:0] r3;
        start();
        xbyte({ADDR, 1'b0, 1'b1}, r0);
        xbyte({ptr, 1'b1}, r1);
        xbyte({d[15:8], 1'b1}, r2);
        xbyte({d[7:0], 1'b1}, r3);
        stop();
        ok = !(r0[0] | r1[0] | r2[0] | r3[0]);
    endtask
    // the last byte is refused so the target lets go of the line
    task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d,
                            output logic ok);
        logic [8:0] r0;
        logic [8:0] r1;
        logic [8:0] r2;
        logic [8:0] r3;
        start();
        xbyte({ADDR, 1'b0, 1'b1}, r0);
        xbyte({ptr, 1'b1}, r1);
        start();
        xbyte({ADDR, 1'b1, 1'b1}, r2);
        xbyte(9'h1FF, r3);
        stop();
        d  = r3[8:1];
        ok = !(r0[0] | r1[0] | r2[0]);
    endtask
endmodule

// >>> verification/psa_top_tb.sv
// self-checking bench of the port status and interrupt block
`timescale 1ns/1ps
`include "psa_defines.svh"
`define PSA_CHK(nm, e, g) \
    checks_done++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("[ERR] %s expected %h seen %h", nm, e, g); \
    end
module psa_top_tb;
    import psa_pkg::*;
    // ========================================
    // signals
    logic       clk_i;
    logic       rst_n_i;
    logic [3:0] pwr;
    logic [3:0] cd;
    logic       sink;
    logic       mode;
    logic [1:0] pins;
    logic       scl_i;
    logic       sda_i;
    logic       pull;
    logic       sda_o;
    logic       sda_oe_o;
    logic       irq_o;
    logic       any_o;
    logic [3:0] hp_o;
    logic [1:0] sel_o;
    logic [1:0] pm_o;
    logic [1:0] edr_o;
    logic [1:0] ddc_o;
    logic [7:0] rd;
    logic       ok;
    logic [7:0] ctrl;
    logic [3:0] aux;
    logic [1:0] cur;
    logic [7:0] exp_q[$];
    string      nm_q[$];
    logic [7:0] obs_v;
    logic [7:0] cur_e;
    string      cur_nm;
    int         n_errors;
    int         checks_done;
    event       obs_e;
    assign sda_i = (sda_oe_o ? sda_o : 1'b1) & !pull;
    psa_top dut_u (
        .clk_i(clk_i), .rst_n_i(rst_n_i),
        .port_sense_i(psa_port_sense_t'({pwr, cd})),
        .sink_hotplug_in_i(sink), .reg_mode_sel_i(mode),
        .port_sel_pins_i(pins), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .irq_o(irq_o), .any_source_power_flag_o(any_o),
        .port_hotplug_out_o(hp_o), .selected_port_o(sel_o),
        .power_mode_o(pm_o), .edge_rate_o(edr_o),
        .ddc_low_level_select_o(ddc_o)
    );
    // bus quarter shortened to keep the run brief
    psa_host_model #(.ADDR(`PSA_DEV_ADDR_DEF), .QTR(25)) host_u (
        .clk_i(clk_i), .sda_i(sda_i), .scl_o(scl_i), .sda_pull_o(pull)
    );
    // ========================================
    // helpers
    function automatic logic [3:0] hp_of(logic [1:0] s);
        for (int i = 0; i < 4; i++) begin
            hp_of[i] = (s == 2'(i)) ? sink : pwr[i];
        end
    endfunction
    function automatic logic [1:0] pick(logic [1:0] pr, logic [1:0] c);
        pick = c;
        for (int k = 3; k >= 0; k--) begin
            if (pwr[2'(pr + k)]) begin
                pick = 2'(pr + k);
            end
        end
    endfunction
    task automatic expect_val(input string nm, input logic [7:0] e,
                              input logic [7:0] g);
        nm_q.push_back(nm);
        exp_q.push_back(e);
        obs_v = g;
        -> obs_e;
        @(posedge clk_i);
    endtask
    task automatic settle();
        repeat (8) @(posedge clk_i);
    endtask
    task automatic read_status(input logic [1:0] s);
        host_u.read_reg(`PSA_REG_STATUS, rd, ok);
        settle();
        expect_val("status", {1'b0, cd[s], s, pwr}, rd);
        expect_val("irq read", 8'h00, 8'(irq_o));
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ========================================
    // clock, watcher, watchdog
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        forever begin
            @(obs_e);
            cur_nm = nm_q.pop_front();
            cur_e  = exp_q.pop_front();
            `PSA_CHK(cur_nm, cur_e, obs_v)
        end
    end
    initial begin
        // about eight bus frames of some 3800 cycles each, doubled
        repeat (60000) @(posedge clk_i);
        n_errors++;
        conclude();
    end
    // ========================================
    // tests
    initial begin
        n_errors = 0;
        checks_done = 0;
        rst_n_i = 1'b0;
        {pwr, cd, sink, mode, pins} = '0;
        void'($urandom(93));
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            {pwr, cd, sink} <= 9'($urandom);
            pins <= 2'(i);
            settle();
            expect_val("pin sel", 8'(i), 8'(sel_o));
            expect_val("pin irq", 8'(cd[i]), 8'(irq_o));
            expect_val("any pwr", 8'(|pwr), 8'(any_o));
            expect_val("hotplug", 8'(hp_of(2'(i))), 8'(hp_o));
        end
        $display("test pin mode done");
        mode <= 1'b1;
        settle();
        read_status(2'h0);
        host_u.write_regs(`PSA_REG_CONTROL, 16'h0200, ok);
        settle();
        expect_val("ack", 8'h01, 8'(ok));
        expect_val("irq sel", 8'h01, 8'(irq_o));
        read_status(2'h2);
        pwr <= pwr ^ 4'h1;
        settle();
        expect_val("irq pwr", 8'h01, 8'(irq_o));
        read_status(2'h2);
        cd <= cd ^ 4'h1;
        settle();
        expect_val("irq other", 8'h00, 8'(irq_o));
        cd <= cd ^ 4'h4;
        settle();
        expect_val("irq clk", 8'h01, 8'(irq_o));
        $display("test interrupt done");
        cur = 2'h2;
        for (int pr = 0; pr < 4; pr++) begin
            ctrl = {2'($urandom), 1'b1, 2'(pr), 3'h0};
            aux  = 4'($urandom);
            host_u.write_regs(`PSA_REG_CONTROL, {ctrl, 4'h0, aux}, ok);
            settle();
            expect_val("ack", 8'h01, 8'(ok));
            expect_val("pmode", 8'(ctrl[7:6]), 8'(pm_o));
            expect_val("edge", 8'(aux[1:0]), 8'(edr_o));
            expect_val("ddc", 8'(aux[3:2]), 8'(ddc_o));
            cur = pick(2'(pr), cur);
            expect_val("auto", 8'(cur), 8'(sel_o));
            pwr <= (pr == 3) ? 4'h0 : 4'($urandom);
            settle();
            cur = pick(2'(pr), cur);
            expect_val("auto pwr", 8'(cur), 8'(sel_o));
        end
        $display("test auto choice done");
        pwr  <= 4'hF;
        // never the priority port, so a stuck automatic choice shows
        pins <= 2'($urandom_range(2));
        mode <= 1'b0;
        settle();
        expect_val("pin auto", 8'(pins), 8'(sel_o));
        $display("test auto in pin mode done");
        conclude();
    end
endmodule
